// [hdl/wake_frame_match_config.sv]
// Behaviour
// - five select bits at 6:2 for id 4..0
// - reserved mask and length bits read zero
// - four-bit length code in bits 3:0
// - codes 0 to 7 mean that many bytes
// - codes 8 to 15 mean eight bytes
// - length code must match bit for bit
// - zero code is empty payload and cleared state
// - eight payload byte registers, bit 0 lsb
// - reset clears length and payload registers
// - only selected id bits are compared
`timescale 1ns/1ns
`default_nettype none
module wake_frame_match_config #(
  parameter int PAYLOAD_BYTES = 8
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire wake_match_pkg::reg_req_t req_in,
  input wire logic frame_valid_in,
  input wire wake_match_pkg::wake_frame_t frame_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic wake_up_frame_out,
  output logic [3:0] payload_bytes_out
);
  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  // payload offsets cover eight registers and no length code asks
  // for more than eight bytes, so no other count can be served
  if (PAYLOAD_BYTES != 8) begin : g_payload_bytes_check
    $error("wake frame match supports eight payload bytes only");
  end

  // ---------------------------------------------------------------
  // storage and match terms
  // ---------------------------------------------------------------
  // configuration registers
  logic [4:0] low_id_compare_select;
  logic [3:0] wake_frame_length_code;
  logic [7:0] expected_payload [PAYLOAD_BYTES];
  // match terms of the frame on frame_in
  logic [PAYLOAD_BYTES*8-1:0] expected_flat;
  logic payload_equal;
  logic id_equal;
  logic length_equal;
  logic [3:0] configured_bytes;
  // write strobes and the write data they carry
  logic write_select;
  logic write_length;
  logic write_payload;
  logic [2:0] write_index;
  logic [4:0] select_bits;
  // read value of the addressed register
  logic [7:0] next_rdata;

  // byte number served by a payload offset: 0x2C is byte seven
  function automatic logic [2:0] payload_index(input logic [6:0] addr);
    logic [6:0] diff;
    diff = wake_match_pkg::ADDR_PAYLOAD_ZERO - addr;
    return diff[2:0];
  endfunction

  function automatic logic is_payload(input logic [6:0] addr);
    return addr >= wake_match_pkg::ADDR_PAYLOAD_SEVEN &&
           addr <= wake_match_pkg::ADDR_PAYLOAD_ZERO;
  endfunction

  // byte count from a length code
  function automatic logic [3:0] bytes_of(input logic [3:0] code);
    return code[3] ? wake_match_pkg::MAX_BYTES : code;
  endfunction

  // compare-select register sits alone at its offset
  function automatic logic is_select(input logic [6:0] addr);
    return addr == wake_match_pkg::ADDR_LOW_ID_SELECT;
  endfunction

  // length-code register sits alone at its offset
  function automatic logic is_length(input logic [6:0] addr);
    return addr == wake_match_pkg::ADDR_LENGTH_CODE;
  endfunction

  // ---------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------
  // writes to unmapped offsets raise no strobe and are dropped
  assign write_select = req_in.write && is_select(req_in.addr);
  assign write_length = req_in.write && is_length(req_in.addr);
  assign write_payload = req_in.write && is_payload(req_in.addr);
  assign write_index = payload_index(req_in.addr);
  assign select_bits = req_in.wdata[wake_match_pkg::SELECT_MSB:wake_match_pkg::SELECT_LSB];

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // compare-select register, a set bit puts its id bit in the compare
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      low_id_compare_select <= wake_match_pkg::SELECT_RESET;
    end else if (write_select) begin
      low_id_compare_select <= select_bits;
    end
  end

  // length code register, zero is the cleared value and no payload
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wake_frame_length_code <= wake_match_pkg::LENGTH_RESET;
    end else if (write_length) begin
      wake_frame_length_code <= req_in.wdata[wake_match_pkg::LENGTH_MSB:0];
    end
  end

  // payload byte registers, bit 0 of each byte is its lsb
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int k = 0; k < PAYLOAD_BYTES; k++) begin
        expected_payload[k] <= wake_match_pkg::PAYLOAD_RESET;
      end
    end else if (write_payload) begin
      expected_payload[write_index] <= req_in.wdata;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read value of the addressed register; reserved bits and
  // unmapped offsets read as zero
  always_comb begin
    next_rdata = 8'h00;
    case (req_in.addr)
      wake_match_pkg::ADDR_LOW_ID_SELECT: begin
        next_rdata = {1'b0, low_id_compare_select, 2'b00};
      end
      wake_match_pkg::ADDR_LENGTH_CODE: begin
        next_rdata = {4'h0, wake_frame_length_code};
      end
      wake_match_pkg::ADDR_PAYLOAD_SEVEN: begin
        next_rdata = expected_payload[7];
      end
      wake_match_pkg::ADDR_PAYLOAD_SIX: begin
        next_rdata = expected_payload[6];
      end
      wake_match_pkg::ADDR_PAYLOAD_FIVE: begin
        next_rdata = expected_payload[5];
      end
      wake_match_pkg::ADDR_PAYLOAD_FOUR: begin
        next_rdata = expected_payload[4];
      end
      wake_match_pkg::ADDR_PAYLOAD_THREE: begin
        next_rdata = expected_payload[3];
      end
      wake_match_pkg::ADDR_PAYLOAD_TWO: begin
        next_rdata = expected_payload[2];
      end
      wake_match_pkg::ADDR_PAYLOAD_ONE: begin
        next_rdata = expected_payload[1];
      end
      wake_match_pkg::ADDR_PAYLOAD_ZERO: begin
        next_rdata = expected_payload[0];
      end
      default: begin
        next_rdata = 8'h00; // unmapped reads zero
      end
    endcase
  end

  // read answer one edge after the request, zero when no read
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.read;
      rdata_out <= req_in.read ? next_rdata : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // frame match
  // ---------------------------------------------------------------
  // payload registers laid out as the frame carries them, byte k at 8k
  always_comb begin
    for (int k = 0; k < PAYLOAD_BYTES; k++) begin
      expected_flat[k*8 +: 8] = expected_payload[k];
    end
  end

  // only selected identifier bits must agree
  assign id_equal = ((frame_in.low_id ^ frame_in.low_id_expected) &
                     low_id_compare_select) == 5'h00;

  // codes must agree bit for bit, an equal byte count is not enough
  assign length_equal = frame_in.length_code == wake_frame_length_code;

  // bytes that take part in the compare, eight for codes from eight up
  assign configured_bytes = bytes_of(wake_frame_length_code);

  // payload compare over the configured number of bytes
  wake_payload_compare #(
    .BYTES(PAYLOAD_BYTES)
  ) payload_cmp (
    .expected_in(expected_flat),
    .received_in(frame_in.payload),
    .byte_count_in(configured_bytes),
    .equal_out(payload_equal)
  );

  // wake decision, registered one cycle after frame_valid_in
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wake_up_frame_out <= 1'b0;
    end else begin
      wake_up_frame_out <= frame_valid_in && id_equal && length_equal &&
                           payload_equal;
    end
  end

  // configured byte count for the frame decoder
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      payload_bytes_out <= 4'h0;
    end else begin
      payload_bytes_out <= configured_bytes;
    end
  end
endmodule
`default_nettype wire

// [hdl/wake_match_pkg.sv]
`default_nettype none
package wake_match_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_LOW_ID_SELECT = 7'h2A;
  localparam logic [6:0] ADDR_LENGTH_CODE = 7'h2B;
  localparam logic [6:0] ADDR_PAYLOAD_SEVEN = 7'h2C;
  localparam logic [6:0] ADDR_PAYLOAD_SIX = 7'h2D;
  localparam logic [6:0] ADDR_PAYLOAD_FIVE = 7'h2E;
  localparam logic [6:0] ADDR_PAYLOAD_FOUR = 7'h2F;
  localparam logic [6:0] ADDR_PAYLOAD_THREE = 7'h30;
  localparam logic [6:0] ADDR_PAYLOAD_TWO = 7'h31;
  localparam logic [6:0] ADDR_PAYLOAD_ONE = 7'h32;
  localparam logic [6:0] ADDR_PAYLOAD_ZERO = 7'h33;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int SELECT_LSB = 2;
  localparam int SELECT_MSB = 6;
  localparam int LENGTH_MSB = 3;
  localparam logic [4:0] SELECT_RESET = 5'h00;
  localparam logic [3:0] LENGTH_RESET = 4'h0;
  localparam logic [7:0] PAYLOAD_RESET = 8'h00;
  localparam logic [3:0] MAX_BYTES = 4'h8;

  // received frame fields presented to the matcher
  typedef struct packed {
    logic [4:0] low_id;
    logic [4:0] low_id_expected;
    logic [3:0] length_code;
    logic [63:0] payload;
  } wake_frame_t;

  // register write or read request
  typedef struct packed {
    logic write;
    logic read;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// [hdl/wake_payload_compare.sv]
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------
// byte-wise payload compare over the first length bytes
// -----------------------------------------------------------------
module wake_payload_compare #(
  parameter int BYTES = 8
) (
  input wire logic [BYTES*8-1:0] expected_in,
  input wire logic [BYTES*8-1:0] received_in,
  input wire logic [3:0] byte_count_in,
  output logic equal_out
);
  // the four-bit byte count reaches eight bytes at most
  if (BYTES != 8) begin : g_bytes_check
    $error("payload compare supports eight bytes only");
  end

  // byte k takes part only when k is below the byte count
  always_comb begin
    equal_out = 1'b1;
    for (int k = 0; k < BYTES; k++) begin
      if (4'(k) < byte_count_in && expected_in[k*8 +: 8] != received_in[k*8 +: 8]) begin
        equal_out = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  output var wake_match_pkg::reg_req_t req_out
);
  initial req_out = '0;
  // one access held over one edge; read data taken the cycle after
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clock_in);
    req_out = '{w, !w, a, d};
    @(negedge clock_in);
    req_out = '0;
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// [tb/test_wake_frame_match_config.sv]
`timescale 1ns/1ns
`default_nettype none
module test_wake_frame_match_config;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic frame_valid_in = 1'b0;
  wake_match_pkg::wake_frame_t frame_in = '0;
  wake_match_pkg::reg_req_t req;
  logic [7:0] rdata_out, q;
  logic [63:0] p;
  logic rvalid_out, wake_up_frame_out;
  logic [3:0] payload_bytes_out, n;
  int err_total = 0, compares = 0;
  initial forever #5 clock_in = ~clock_in;
  host_model host_u (.clock_in(clock_in), .rdata_in(rdata_out), .req_out(req));
  wake_frame_match_config dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_in(req),
    .frame_valid_in(frame_valid_in), .frame_in(frame_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .wake_up_frame_out(wake_up_frame_out),
    .payload_bytes_out(payload_bytes_out));
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", s, e, g);
      err_total++;
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host_u.acc(1'b0, a, 8'h00, q);
    cmp("rdata", e, q);
    cmp("rvalid", 8'h01, {7'h00, rvalid_out});
  endtask
  // one received frame, wake result checked the cycle after
  task automatic frm(input logic [3:0] c, input logic [63:0] d, input logic [4:0] id,
    input logic e);
    @(negedge clock_in);
    frame_valid_in = 1'b1;
    frame_in = '{id, 5'h15, c, d};
    @(negedge clock_in);
    frame_valid_in = 1'b0;
    cmp("wake", {7'h00, e}, {7'h00, wake_up_frame_out});
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // reset values, field masks, payload bytes, length codes, id selection
  initial begin
    repeat (20) @(negedge clock_in);
    sys_rst_in = 1'b0;
    for (int a = 8'h2A; a <= 8'h34; a++) rd(a[6:0], 8'h00);
    host_u.acc(1'b1, 7'h2A, 8'hFF, q);
    rd(7'h2A, 8'h7C);
    host_u.acc(1'b1, 7'h2B, 8'hFF, q);
    rd(7'h2B, 8'h0F);
    for (int k = 0; k < 8; k++) begin
      p[8*k +: 8] = {k[3:0] + 4'h1, 4'hA};
      host_u.acc(1'b1, 7'h33 - k[6:0], p[8*k +: 8], q);
      rd(7'h33 - k[6:0], p[8*k +: 8]);
    end
    $display("register test done");
    for (int c = 0; c < 16; c++) begin
      n = (c > 8) ? 4'h8 : c[3:0];
      host_u.acc(1'b1, 7'h2B, {4'h0, c[3:0]}, q);
      frm(c[3:0], p, 5'h15, 1'b1);
      cmp("bytes", {4'h0, n}, {4'h0, payload_bytes_out});
      frm(c[3:0] ^ 4'h1, p, 5'h15, 1'b0);
      frm(c[3:0], p ^ (64'hFF << (8 * ((n == 0) ? 0 : n - 1))), 5'h15, n == 0);
      if (n < 8) frm(c[3:0], p ^ (64'hFF << (8 * n)), 5'h15, 1'b1);
    end
    frm(4'hF, p, 5'h14, 1'b0);
    host_u.acc(1'b1, 7'h2A, 8'h78, q);
    frm(4'hF, p, 5'h14, 1'b1);
    @(negedge clock_in);
    sys_rst_in = 1'b1;
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    rd(7'h2B, 8'h00);
    rd(7'h2C, 8'h00);
    cmp("bytes", 8'h00, {4'h0, payload_bytes_out});
    $display("match test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// [tb/wake_match_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module wake_match_properties (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire wake_match_pkg::reg_req_t req_in,
  input wire logic frame_valid_in,
  input wire wake_match_pkg::wake_frame_t frame_in,
  input wire logic [7:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic wake_up_frame_out,
  input wire logic [3:0] payload_bytes_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // read answered on the next edge
  sequence s_rd; req_in.read ##1 rvalid_out; endsequence
  property p_rd; req_in.read |-> s_rd; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_nr; !req_in.read |=> !rvalid_out && rdata_out == 8'h00; endproperty
  a_nr: assert property (p_nr) else $error("stray read data");
  property p_sel; rvalid_out && $past(req_in.addr) == 7'h2A |-> rdata_out[7] == 1'b0
    && rdata_out[1:0] == 2'h0; endproperty
  a_sel: assert property (p_sel) else $error("select reserved set");
  property p_len; rvalid_out && $past(req_in.addr) == 7'h2B |-> rdata_out[7:4] == 4'h0;
  endproperty
  a_len: assert property (p_len) else $error("length reserved set");
  property p_max; payload_bytes_out <= 4'h8; endproperty
  a_max: assert property (p_max) else $error("byte count above eight");
  property p_clr; $past(sys_rst_in) |-> payload_bytes_out == 4'h0 && !wake_up_frame_out;
  endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  property p_idle; !frame_valid_in |=> !wake_up_frame_out; endproperty
  a_idle: assert property (p_idle) else $error("wake without frame");
  property p_dlc; frame_valid_in && !req_in.write && !$past(req_in.write)
    && frame_in.length_code < 4'h8 && payload_bytes_out < 4'h8
    && frame_in.length_code != payload_bytes_out |=> !wake_up_frame_out; endproperty
  a_dlc: assert property (p_dlc) else $error("length code mismatch woke");
endmodule
bind wake_frame_match_config wake_match_properties chk_u (.clock_in(clock_in),
  .sys_rst_in(sys_rst_in), .req_in(req_in), .frame_valid_in(frame_valid_in),
  .frame_in(frame_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .wake_up_frame_out(wake_up_frame_out), .payload_bytes_out(payload_bytes_out));
`default_nettype wire
